// ---- sim/sampler_payload_writeback_packer_tb.sv ----
// Bench joining the thread end and the sampler end, core results driven here
`timescale 1ns/1ps
module sampler_payload_writeback_packer_tb;
  import spw_pkg::*;
  logic          i_sys_clk, i_rst_b, go, fmt, nen, res_vld, wv, wl, done, pv_o, pl_o, len_err;
  spw_mode_t     mode;
  spw_msg_t      typ;
  logic [3:0]    chm, npar;
  logic [15:0]   exec;
  logic [2047:0] par, res;
  logic [1023:0] uvh;
  logic [255:0]  wd, pd, d, ed[$], gd[$], ei[$], gi[$];
  logic [7:0]    we, ee[$], ge[$];
  int            errors, n_checks;
  spw_link_if lnk();
  spw_host u_spw_host (.i_sys_clk(i_sys_clk), .i_rst_b(i_rst_b), .lnk(lnk), .i_go(go), .i_mode(mode),
    .i_type(typ), .i_fmt16(fmt), .i_chmask(chm), .i_exec(exec), .i_null_en(nen), .i_npar(npar), .i_par(par),
    .i_uv_hi(uvh), .o_busy(), .o_wb_vld(wv), .o_wb_data(wd), .o_wb_dw_en(we), .o_wb_last(wl), .o_done(done));
  spw_dev u_spw_dev (.i_sys_clk(i_sys_clk), .i_rst_b(i_rst_b), .lnk(lnk), .o_par_vld(pv_o), .o_par_data(pd),
    .o_par_idx(), .o_par_last(pl_o), .o_hdr_mode(), .o_hdr_type(), .o_hdr_fmt16(), .i_res_vld(res_vld),
    .i_res_data(res), .i_res_null(16'h5AA5), .i_res_live(8'h3C), .o_busy(), .o_len_err(len_err));
  spw_link_chk u_chk (.i_sys_clk(i_sys_clk), .i_rst_b(i_rst_b), .req_vld(lnk.req_vld), .req_rdy(lnk.req_rdy),
    .req_data(lnk.req_data), .req_last(lnk.req_last), .req_mode(lnk.req_mode), .req_fmt16(lnk.req_fmt16),
    .req_exec(lnk.req_exec), .req_null_en(lnk.req_null_en), .wb_vld(lnk.wb_vld), .wb_data(lnk.wb_data),
    .wb_dw_en(lnk.wb_dw_en), .wb_last(lnk.wb_last));
  // Distinct patterns: parameter, upper double half, result
  function automatic logic [31:0] pv(input int p, l); return {8'(p), 8'(l), 16'h5A5A}; endfunction
  function automatic logic [31:0] hv(input int p, l); return {8'(p), 8'(l), 16'hC3C3}; endfunction
  function automatic logic [31:0] rv(input int c, l); return {16'h7E7E, 8'(c), 8'(l)}; endfunction
  task automatic chk(input string nm, input logic [255:0] e, g);
    n_checks++;
    if (g !== e) begin
      errors++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic exp_reg(input logic [255:0] v, input logic [7:0] e);
    ed.push_back(v);
    ee.push_back(e);
  endtask
  task automatic in_beat(input int p, off);
    for (int j = 0; j < 8; j++) d[32*j +: 32] = pv(p, off + j);
    ei.push_back(d);
  endtask
  task automatic wb_beat(input int c, off, input logic [7:0] e);
    for (int j = 0; j < 8; j++) d[32*j +: 32] = rv(c, off + j);
    exp_reg(d, e);
  endtask
  task automatic wait_hi(ref logic s);
    int k;
    k = 0;
    do begin
      @(posedge i_sys_clk);
      #1;
      k++;
    end while (s !== 1'b1 && k < 200);
    if (s !== 1'b1) begin
      errors++;
      $display("[FAIL] wait_hi expected 1 seen %b", s);
    end
  endtask
  // One message through both ends, then every register compared on its written dwords
  task automatic run(input spw_mode_t m, input spw_msg_t t, input logic f, input logic [3:0] cm,
                     input logic ne, input logic [3:0] np, input logic [15:0] ex);
    logic [255:0] msk;
    gd.delete(); ge.delete(); gi.delete();
    @(posedge i_sys_clk);
    mode <= m; typ <= t; fmt <= f; chm <= cm; nen <= ne; npar <= np; exec <= ex;
    go <= 1'b1;
    @(posedge i_sys_clk) go <= 1'b0;
    wait_hi(pl_o);
    @(posedge i_sys_clk) res_vld <= 1'b1;
    @(posedge i_sys_clk) res_vld <= 1'b0;
    wait_hi(done);
    chk("wb_last", 256'(1), 256'(wl));
    @(posedge i_sys_clk);
    #1;
    chk("wb_count", 256'(ed.size()), 256'(gd.size()));
    chk("par_count", 256'(ei.size()), 256'(gi.size()));
    for (int i = 0; i < ed.size() && i < gd.size(); i++) begin
      foreach (msk[b]) msk[b] = ee[i][b / 32];
      chk("wb_data", ed[i] & msk, gd[i] & msk);
      chk("wb_dw_en", 256'(ee[i]), 256'(ge[i]));
    end
    for (int i = 0; i < ei.size() && i < gi.size(); i++) chk("par_data", ei[i], gi[i]);
    chk("len_err", 256'(0), 256'(len_err));
    ed.delete(); ee.delete(); ei.delete();
  endtask
  task automatic t_sixteen32;
    in_beat(0, 0);
    in_beat(0, 8);
    wb_beat(0, 0, 8'hFF);
    wb_beat(0, 8, 8'hF0);
    wb_beat(3, 0, 8'hFF);
    wb_beat(3, 8, 8'hF0);
    exp_reg({224'h0, 16'hFFFF, 16'h5AA5}, 8'h01);
    run(SIXTEEN_LANE_MODE, MT_SAMPLE, 1'b0, 4'b0110, 1'b1, 4'h1, 16'hF0FF);
  endtask
  task automatic t_sixteen16;
    in_beat(0, 0);
    in_beat(0, 8);
    for (int c = 0; c < 4; c++) begin
      for (int j = 0; j < 8; j++) d[32*j +: 32] = {16'(rv(c, 2*j+1)), 16'(rv(c, 2*j))};
      exp_reg(d, 8'hFF);
    end
    run(SIXTEEN_LANE_MODE, MT_TEXEL_LOAD, 1'b1, 4'h0, 1'b0, 4'h1, 16'hFFFF);
  endtask
  task automatic t_eight_kill;
    in_beat(0, 0);
    in_beat(1, 0);
    wb_beat(0, 0, 8'hA5);
    exp_reg({224'h0, 32'hFFFFFF3C}, 8'h01);
    run(EIGHT_LANE_MODE, MT_SAMPLE_KILL, 1'b0, 4'b1110, 1'b0, 4'h2, 16'h00A5);
  endtask
  task automatic t_double;
    for (int b = 0; b < 4; b++) begin
      for (int q = 0; q < 4; q++) d[64*q +: 64] = {hv(b/2, 4*(b%2)+q), pv(b/2, 4*(b%2)+q)};
      ei.push_back(d);
    end
    wb_beat(3, 0, 8'hFF);
    exp_reg({224'h0, 24'hFFFFFF, 8'hA5}, 8'h01);
    run(DOUBLE_COORD_EIGHT_LANE_MODE, MT_SAMPLE, 1'b0, 4'b0111, 1'b1, 4'h2, 16'hFFFF);
  endtask
  task automatic t_two_sample;
    for (int j = 0; j < 8; j++) d[32*j +: 32] = pv(j%4, j/4);
    ei.push_back(d);
    for (int j = 0; j < 8; j++) d[32*j +: 32] = rv(j%4, j/4);
    exp_reg(d, 8'hD0);
    exp_reg({224'h0, 30'h3FFFFFFF, 2'b01}, 8'h01);
    run(TWO_SAMPLE_VECTOR_MODE, MT_SIZE_QUERY, 1'b0, 4'b0010, 1'b1, 4'h4, 16'h00F0);
  endtask
  task automatic give_verdict;
    if (errors == 0 && n_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  // Host-side writeback and core-side parameter monitors
  always @(posedge i_sys_clk) begin
    if (wv === 1'b1) begin
      gd.push_back(wd);
      ge.push_back(we);
    end
    if (pv_o === 1'b1) gi.push_back(pd);
  end
  initial begin
    i_sys_clk = 1'b0;
    forever #5 i_sys_clk = ~i_sys_clk;
  end
  // Watchdog at 20000 cycles, far beyond the under 100 cycles the messages need
  initial begin
    #200000;
    errors++;
    give_verdict();
  end
  initial begin
    for (int i = 0; i < 64; i++) par[32*i +: 32] = pv(i/16, i%16);
    for (int i = 0; i < 64; i++) res[32*i +: 32] = rv(i/16, i%16);
    for (int i = 0; i < 32; i++) uvh[32*i +: 32] = hv(i/16, i%16);
    i_rst_b = 1'b0;
    go = 1'b0;
    res_vld = 1'b0;
    mode = SIXTEEN_LANE_MODE;
    typ = MT_SAMPLE;
    fmt = 1'b0;
    nen = 1'b0;
    chm = 4'h0;
    npar = 4'h1;
    exec = 16'hFFFF;
    errors = 0;
    n_checks = 0;
    repeat (4) @(posedge i_sys_clk);
    i_rst_b <= 1'b1;
    @(posedge i_sys_clk);
    t_sixteen32();
    t_sixteen16();
    t_eight_kill();
    t_double();
    t_two_sample();
    give_verdict();
  end
endmodule

// ---- sim/spw_link_chk.sv ----
// Concurrent checks on the link between the thread end and the sampler end
`timescale 1ns/1ps
module spw_link_chk
  import spw_pkg::*;
(
  input wire logic             i_sys_clk,
  input wire logic             i_rst_b,
  input wire logic             req_vld,
  input wire logic             req_rdy,
  input wire logic [REGW-1:0]  req_data,
  input wire logic             req_last,
  input wire spw_mode_t        req_mode,
  input wire logic             req_fmt16,
  input wire logic [NLANE-1:0] req_exec,
  input wire logic             req_null_en,
  input wire logic             wb_vld,
  input wire logic [REGW-1:0]  wb_data,
  input wire logic [NDW-1:0]   wb_dw_en,
  input wire logic             wb_last
);
  spw_mode_t        mode_ff; // Header of the message in flight
  logic             fmt_ff;
  logic             null_ff;
  logic [NLANE-1:0] exec_ff;
  // Header captured at each take, since the host may move on after the last beat
  always_ff @(posedge i_sys_clk) begin
    if (req_vld && req_rdy) begin
      mode_ff <= req_mode;
      fmt_ff  <= req_fmt16;
      null_ff <= req_null_en;
      exec_ff <= req_exec;
    end
  end
  default clocking @(posedge i_sys_clk); endclocking
  default disable iff (!i_rst_b);
  sequence s_stall; req_vld && !req_rdy; endsequence
  sequence s_take_last; req_vld && req_rdy && req_last; endsequence
  sequence s_wb_mid; wb_vld && !wb_last; endsequence
  property p_req_hold; s_stall |=> req_vld && $stable(req_data) && $stable(req_last); endproperty
  property p_refuse; s_take_last |=> !req_rdy [*2]; endproperty
  property p_wb_burst; s_wb_mid |=> wb_vld; endproperty
  property p_wb_end; wb_vld && wb_last |=> !wb_vld; endproperty
  property p_wb_quiet; wb_vld |-> !req_rdy && !req_vld; endproperty
  property p_two_extra; wb_vld && !wb_last && mode_ff == TWO_SAMPLE_VECTOR_MODE
    |=> wb_last && wb_dw_en == 8'h01 && wb_data[31:2] == 30'h3FFFFFFF; endproperty
  property p_null16; wb_vld && wb_last && null_ff && mode_ff == SIXTEEN_LANE_MODE
    |-> wb_data[31:16] == 16'hFFFF && wb_dw_en == 8'h01; endproperty
  property p_dw_en; wb_vld && !wb_last && mode_ff == SIXTEEN_LANE_MODE && !fmt_ff
    |-> wb_dw_en == exec_ff[7:0] || wb_dw_en == exec_ff[15:8]; endproperty
  a_req_hold: assert property (p_req_hold) else $error("stalled request changed");
  a_refuse: assert property (p_refuse) else $error("ready after last beat");
  a_wb_burst: assert property (p_wb_burst) else $error("writeback gap");
  a_wb_end: assert property (p_wb_end) else $error("writeback past last");
  a_wb_quiet: assert property (p_wb_quiet) else $error("request during writeback");
  a_two_extra: assert property (p_two_extra) else $error("two-sample extra register wrong");
  a_null16: assert property (p_null16) else $error("sixteen-lane extra register wrong");
  a_dw_en: assert property (p_dw_en) else $error("dword enables not from exec mask");
endmodule

// ---- src/spw_dev.sv ----
// Sampler end: takes input registers, hands them to the core, packs writeback registers
//
// The register offsets and the strobed register port were chosen for this implementation.
`timescale 1ns/1ps
module spw_dev
  import spw_pkg::*;
(
  input  wire logic                      i_sys_clk,
  input  wire logic                      i_rst_b,
  spw_link_if.dev                        lnk,
  output logic                           o_par_vld,  // One input register for the core
  output logic [REGW-1:0]                o_par_data,
  output logic [4:0]                     o_par_idx,
  output logic                           o_par_last,
  output spw_mode_t                      o_hdr_mode, // Header of the current message
  output spw_msg_t                       o_hdr_type,
  output logic                           o_hdr_fmt16,
  input  wire logic                      i_res_vld,  // Core results ready, one cycle
  input  wire logic [NCH*NLANE*DW-1:0]   i_res_data, // Per channel, per lane
  input  wire logic [NLANE-1:0]          i_res_null, // Low where a null page fed the pixel
  input  wire logic [7:0]                i_res_live, // Low where chroma key killed the pixel
  output logic                           o_busy,
  output logic                           o_len_err   // Declared length disagreed
);
  spw_state_t             st_ff;      // Message phase
  logic [4:0]             pidx_ff;    // Input register count
  logic [3:0]             widx_ff;    // Writeback register index
  logic [3:0]             len_ff;     // Writeback length
  logic [3:0]             chmask_ff;  // Channel skip mask
  logic [NLANE-1:0]       exec_ff;    // Execution mask
  logic                   null_en_ff; // Null/fault mask enable
  logic [NCH*NLANE*DW-1:0] res_ff;    // Latched core results
  logic [NLANE-1:0]       null_ff;    // Latched null mask
  logic [7:0]             live_ff;    // Latched kill mask
  logic [REGW-1:0]        nxt_data;   // Writeback image of widx_ff
  logic [NDW-1:0]         nxt_dw_en;  // Written dwords of widx_ff
  logic [3:0]             nxt_len;    // Length from the incoming header
  logic                   take;       // Input register accepted

  assign take    = lnk.req_vld && lnk.req_rdy;
  assign nxt_len = spw_resp_len(lnk.req_mode, lnk.req_fmt16, lnk.req_chmask, lnk.req_null_en,
                                lnk.req_type);

  // Channel result of one lane
  function automatic logic [DW-1:0] res_of(input logic [NCH*NLANE*DW-1:0] r, input int c,
                                           input int l);
    return r[(c*NLANE+l)*DW +: DW];
  endfunction

  // Build the writeback register at widx_ff; values pass through in their own encoding
  always_comb begin
    logic [1:0] ch;
    logic [3:0] slot;
    logic       half;
    logic       wide;
    int         cnt;
    int         ln;
    ln        = 0;
    nxt_data  = '0;
    nxt_dw_en = '0;
    ch        = 2'h0;
    wide      = (o_hdr_mode == SIXTEEN_LANE_MODE) && !o_hdr_fmt16;
    slot      = wide ? {1'b0, widx_ff[3:1]} : widx_ff;
    half      = wide & widx_ff[0];
    cnt       = 0;
    // Find the slot-th enabled channel so skipped ones close up
    for (int c = 0; c < NCH; c++) begin
      if (!chmask_ff[c]) begin
        if (cnt == int'(slot)) begin
          ch = 2'(c);
        end
        cnt = cnt + 1;
      end
    end
    if (o_hdr_mode == TWO_SAMPLE_VECTOR_MODE) begin
      if (widx_ff == 4'h0) begin
        for (int d = 0; d < NDW; d++) begin
          nxt_data[d*DW +: DW] = res_of(res_ff, d % 4, d / 4);
          nxt_dw_en[d] = !chmask_ff[d % 4] && |exec_ff[4*(d/4) +: 4];
        end
      end else begin
        nxt_data[DW-1:0] = {NULL_FILL30, null_ff[1:0]};
        nxt_dw_en        = DWEN_FIRST;
      end
    end else if (int'(slot) >= int'(spw_nch(chmask_ff))) begin
      // Extra register after the channels, dwords 1 to 7 left alone
      nxt_dw_en = DWEN_FIRST;
      if (o_hdr_mode == SIXTEEN_LANE_MODE) begin
        nxt_data[DW-1:0] = {NULL_FILL16, null_ff};
      end else if (o_hdr_type == MT_SAMPLE_KILL && !o_hdr_fmt16) begin
        nxt_data[DW-1:0] = {NULL_FILL16, KILL_FILL8, live_ff & (null_en_ff ? null_ff[7:0] : 8'hFF)};
      end else begin
        nxt_data[DW-1:0] = {NULL_FILL24, null_ff[7:0]};
      end
    end else begin
      for (int d = 0; d < NDW; d++) begin
        if (o_hdr_fmt16) begin
          // Even pixel in the low half, odd pixel in the high half
          if (o_hdr_mode == SIXTEEN_LANE_MODE || d < 4) begin
            nxt_data[d*DW +: DW] = {res_ff[(int'(ch)*NLANE+2*d+1)*DW +: 16],
                                    res_ff[(int'(ch)*NLANE+2*d)*DW +: 16]};
            nxt_dw_en[d] = exec_ff[2*d] | exec_ff[2*d+1];
          end
        end else begin
          ln = 8 * int'(half) + d;
          nxt_data[d*DW +: DW] = res_of(res_ff, int'(ch), ln);
          nxt_dw_en[d] = exec_ff[ln];
        end
      end
    end
  end

  // Message phase: receive, wait for the core, answer
  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_b) begin
      st_ff   <= ST_IDLE;
      pidx_ff <= 5'h0;
      widx_ff <= 4'h0;
    end else begin
      case (st_ff)
        ST_IDLE, ST_REQ: begin
          if (take) begin
            pidx_ff <= lnk.req_last ? 5'h0 : pidx_ff + 5'h1;
            st_ff   <= lnk.req_last ? ST_WAIT : ST_REQ;
          end
        end
        ST_WAIT: begin
          if (i_res_vld) begin
            widx_ff <= 4'h0;
            st_ff   <= (len_ff == 4'h0) ? ST_IDLE : ST_RESP;
          end
        end
        default: begin
          widx_ff <= widx_ff + 4'h1;
          if (widx_ff == len_ff - 4'h1) begin
            st_ff <= ST_IDLE;
          end
        end
      endcase
    end
  end

  // Header capture on the first register of a message
  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_b) begin
      o_hdr_mode  <= SIXTEEN_LANE_MODE;
      o_hdr_type  <= MT_SAMPLE;
      o_hdr_fmt16 <= 1'b0;
      chmask_ff   <= 4'h0;
      exec_ff     <= '0;
      null_en_ff  <= 1'b0;
      len_ff      <= 4'h0;
      o_len_err   <= 1'b0;
    end else if (take && st_ff == ST_IDLE) begin
      o_hdr_mode  <= lnk.req_mode;
      o_hdr_type  <= lnk.req_type;
      o_hdr_fmt16 <= lnk.req_fmt16;
      chmask_ff   <= lnk.req_chmask;
      exec_ff     <= (lnk.req_mode == SIXTEEN_LANE_MODE || lnk.req_mode == TWO_SAMPLE_VECTOR_MODE) ?
                     lnk.req_exec : {8'h00, lnk.req_exec[7:0]};
      null_en_ff  <= lnk.req_null_en;
      len_ff      <= nxt_len;
      o_len_err   <= (nxt_len != lnk.req_resp_len);
    end
  end

  // Input registers forwarded to the core
  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_b) begin
      o_par_vld  <= 1'b0;
      o_par_data <= '0;
      o_par_idx  <= 5'h0;
      o_par_last <= 1'b0;
    end else begin
      o_par_vld  <= take;
      o_par_data <= lnk.req_data;
      o_par_idx  <= pidx_ff;
      o_par_last <= take && lnk.req_last;
    end
  end

  // Core results held for the whole answer
  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_b) begin
      res_ff  <= '0;
      null_ff <= '0;
      live_ff <= 8'h00;
    end else if (st_ff == ST_WAIT && i_res_vld) begin
      res_ff  <= i_res_data;
      null_ff <= i_res_null;
      live_ff <= i_res_live;
    end
  end

  // Link answer drive
  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_b) begin
      lnk.req_rdy  <= 1'b0;
      lnk.wb_vld   <= 1'b0;
      lnk.wb_data  <= '0;
      lnk.wb_dw_en <= '0;
      lnk.wb_last  <= 1'b0;
      o_busy       <= 1'b0;
    end else begin
      // Ready again after the last writeback beat, or on the core results when the length is zero, so no request overlaps the answer
      lnk.req_rdy  <= (st_ff == ST_IDLE || st_ff == ST_REQ) && !(take && lnk.req_last) ||
                      (st_ff == ST_WAIT && i_res_vld && len_ff == 4'h0);
      lnk.wb_vld   <= (st_ff == ST_RESP);
      lnk.wb_data  <= nxt_data;
      lnk.wb_dw_en <= nxt_dw_en;
      lnk.wb_last  <= (st_ff == ST_RESP) && (widx_ff == len_ff - 4'h1);
      o_busy       <= (st_ff != ST_IDLE) || take;
    end
  end
endmodule

// ---- src/spw_host.sv ----
// Thread end: packs parameters into input registers and collects the writeback
`timescale 1ns/1ps
module spw_host
  import spw_pkg::*;
#(
  parameter int MAX_PAR = 4 // Parameters the sender can hold
) (
  input  wire logic                          i_sys_clk,
  input  wire logic                          i_rst_b,
  spw_link_if.host                           lnk,
  input  wire logic                          i_go,       // Start a message
  input  wire spw_mode_t                     i_mode,
  input  wire spw_msg_t                      i_type,
  input  wire logic                          i_fmt16,
  input  wire logic [3:0]                    i_chmask,
  input  wire logic [NLANE-1:0]              i_exec,
  input  wire logic                          i_null_en,
  input  wire logic [3:0]                    i_npar,     // Parameters in use
  input  wire logic [MAX_PAR*NLANE*DW-1:0]   i_par,      // Per parameter, per lane
  input  wire logic [2*NLANE*DW-1:0]         i_uv_hi,    // Upper halves of double u, v
  output logic                               o_busy,
  output logic                               o_wb_vld,
  output logic [REGW-1:0]                    o_wb_data,
  output logic [NDW-1:0]                     o_wb_dw_en,
  output logic                               o_wb_last,
  output logic                               o_done
);
  spw_state_t      st_ff;        // Message phase
  logic [4:0]      beat_ff;      // Register being offered
  logic [4:0]      nbeat_ff;     // Registers in the message
  logic [REGW-1:0] nxt_data;     // Next register image
  logic [4:0]      nxt_beat;     // Beat to pack
  logic [4:0]      nxt_nbeat;    // Beat count of a new message
  spw_mode_t       mode_ff;      // Latched layout
  logic [3:0]      len;          // Expected writeback length

  assign len = spw_resp_len(i_mode, i_fmt16, i_chmask, i_null_en, i_type);

  // Beat count of a new request
  always_comb begin
    case (i_mode)
      SIXTEEN_LANE_MODE:            nxt_nbeat = {i_npar, 1'b0};
      EIGHT_LANE_MODE:              nxt_nbeat = {1'b0, i_npar};
      DOUBLE_COORD_EIGHT_LANE_MODE: nxt_nbeat = {1'b0, i_npar} + 5'h2;
      default:                      nxt_nbeat = {3'h0, i_npar[3:2]} + {4'h0, |i_npar[1:0]};
    endcase
  end

  // Register image of beat nxt_beat; parameter bits go out untouched in float or U32 form
  always_comb begin
    spw_mode_t m;
    int        p;
    int        ln;
    p  = 0;
    ln = 0;
    m = (st_ff == ST_IDLE) ? i_mode : mode_ff;
    nxt_beat = (st_ff == ST_IDLE) ? 5'h0 : beat_ff + 5'h1;
    nxt_data = '0;
    for (int d = 0; d < NDW; d++) begin
      case (m)
        SIXTEEN_LANE_MODE: begin
          p  = int'(nxt_beat[4:1]);
          ln = 8 * int'(nxt_beat[0]) + d;
        end
        EIGHT_LANE_MODE: begin
          p  = int'(nxt_beat);
          ln = d;
        end
        DOUBLE_COORD_EIGHT_LANE_MODE: begin
          p  = (nxt_beat < 5'h4) ? int'(nxt_beat[1]) : int'(nxt_beat) - 2;
          ln = (nxt_beat < 5'h4) ? 4 * int'(nxt_beat[0]) + d / 2 : d;
        end
        default: begin
          p  = 4 * int'(nxt_beat) + d % 4;
          ln = d / 4;
        end
      endcase
      if (p < MAX_PAR) begin
        if (m == DOUBLE_COORD_EIGHT_LANE_MODE && nxt_beat < 5'h4 && d % 2 == 1) begin
          nxt_data[d*DW +: DW] = i_uv_hi[(p*NLANE+ln)*DW +: DW];
        end else begin
          nxt_data[d*DW +: DW] = i_par[(p*NLANE+ln)*DW +: DW];
        end
      end
    end
  end

  // Message sequencing
  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_b) begin
      st_ff    <= ST_IDLE;
      beat_ff  <= 5'h0;
      nbeat_ff <= 5'h0;
      mode_ff  <= SIXTEEN_LANE_MODE;
    end else begin
      case (st_ff)
        ST_IDLE: begin
          if (i_go && nxt_nbeat != 5'h0) begin
            st_ff    <= ST_REQ;
            beat_ff  <= 5'h0;
            nbeat_ff <= nxt_nbeat;
            mode_ff  <= i_mode;
          end
        end
        ST_REQ: begin
          if (lnk.req_rdy) begin
            if (beat_ff == nbeat_ff - 5'h1) begin
              st_ff <= (lnk.req_resp_len == 4'h0) ? ST_IDLE : ST_RESP;
            end else begin
              beat_ff <= nxt_beat;
            end
          end
        end
        default: begin
          if (lnk.wb_vld && lnk.wb_last) begin
            st_ff <= ST_IDLE;
          end
        end
      endcase
    end
  end

  // Link request drive
  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_b) begin
      lnk.req_vld      <= 1'b0;
      lnk.req_data     <= '0;
      lnk.req_last     <= 1'b0;
      lnk.req_mode     <= SIXTEEN_LANE_MODE;
      lnk.req_type     <= MT_SAMPLE;
      lnk.req_fmt16    <= 1'b0;
      lnk.req_chmask   <= 4'h0;
      lnk.req_exec     <= '0;
      lnk.req_null_en  <= 1'b0;
      lnk.req_resp_len <= 4'h0;
    end else if (st_ff == ST_IDLE && i_go && nxt_nbeat != 5'h0) begin
      lnk.req_vld      <= 1'b1;
      lnk.req_data     <= nxt_data;
      lnk.req_last     <= (nxt_nbeat == 5'h1);
      lnk.req_mode     <= i_mode;
      lnk.req_type     <= i_type;
      lnk.req_fmt16    <= i_fmt16;
      lnk.req_chmask   <= i_chmask;
      lnk.req_exec     <= i_exec;
      lnk.req_null_en  <= i_null_en;
      lnk.req_resp_len <= len;
    end else if (st_ff == ST_REQ && lnk.req_rdy) begin
      lnk.req_vld  <= (beat_ff != nbeat_ff - 5'h1);
      lnk.req_data <= nxt_data;
      lnk.req_last <= (nxt_beat == nbeat_ff - 5'h1);
    end
  end

  // Writeback hand-off to the thread
  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_b) begin
      o_wb_vld   <= 1'b0;
      o_wb_data  <= '0;
      o_wb_dw_en <= '0;
      o_wb_last  <= 1'b0;
      o_done     <= 1'b0;
      o_busy     <= 1'b0;
    end else begin
      o_wb_vld   <= (st_ff == ST_RESP) && lnk.wb_vld;
      o_wb_data  <= lnk.wb_data;
      o_wb_dw_en <= lnk.wb_dw_en;
      o_wb_last  <= lnk.wb_last;
      o_done     <= ((st_ff == ST_RESP) && lnk.wb_vld && lnk.wb_last) ||
                    ((st_ff == ST_REQ) && lnk.req_rdy && beat_ff == nbeat_ff - 5'h1 &&
                     lnk.req_resp_len == 4'h0);
      o_busy     <= (st_ff == ST_IDLE) ? (i_go && nxt_nbeat != 5'h0) : !o_done;
    end
  end
endmodule

// ---- src/spw_link_if.sv ----
// Link between the issuing thread end and the sampler end, one register per beat
`timescale 1ns/1ps
interface spw_link_if;
  import spw_pkg::*;
  logic             req_vld;      // Input register valid
  logic             req_rdy;      // Sampler end can take a register
  logic [REGW-1:0]  req_data;     // Input message register
  logic             req_last;     // Last register of the message
  spw_mode_t        req_mode;     // Lane layout, held through the message
  spw_msg_t         req_type;     // Message kind
  logic             req_fmt16;    // 16-bit return format
  logic [3:0]       req_chmask;   // Channel skip mask, bit 0 red
  logic [NLANE-1:0] req_exec;     // Execution mask of the send
  logic             req_null_en;  // Single null/fault mask enable
  logic [3:0]       req_resp_len; // Declared writeback length
  logic             wb_vld;       // Writeback register valid
  logic [REGW-1:0]  wb_data;      // Writeback register
  logic [NDW-1:0]   wb_dw_en;     // Dwords actually written
  logic             wb_last;      // Last writeback register

  modport host (output req_vld, req_data, req_last, req_mode, req_type, req_fmt16, req_chmask,
                req_exec, req_null_en, req_resp_len, input req_rdy, wb_vld, wb_data, wb_dw_en, wb_last);
  modport dev (input req_vld, req_data, req_last, req_mode, req_type, req_fmt16, req_chmask,
               req_exec, req_null_en, req_resp_len, output req_rdy, wb_vld, wb_data, wb_dw_en, wb_last);
endinterface

// ---- src/spw_pkg.sv ----
// Shared constants, types and helper functions for the sampler payload packer ends
package spw_pkg;
  localparam int NLANE = 16;  // Lanes of a full request
  localparam int DW    = 32;  // Bits per dword
  localparam int NDW   = 8;   // Dwords per register
  localparam int REGW  = 256; // Bits per message register
  localparam int NCH   = 4;   // Red, green, blue, alpha
  localparam logic [15:0] NULL_FILL16 = 16'hFFFF;     // Upper half of sixteen-lane extra dword
  localparam logic [23:0] NULL_FILL24 = 24'hFFFFFF;   // Upper bits of eight-lane extra dword
  localparam logic [7:0]  KILL_FILL8  = 8'hFF;        // Unused upper kill byte
  localparam logic [29:0] NULL_FILL30 = 30'h3FFFFFFF; // Upper bits of two-sample extra dword
  localparam logic [7:0]  DWEN_ALL    = 8'hFF;        // Every dword written
  localparam logic [7:0]  DWEN_FIRST  = 8'h01;        // Only dword 0 written

  // Lane layout of a message
  typedef enum logic [1:0] {
    SIXTEEN_LANE_MODE            = 2'h0,
    EIGHT_LANE_MODE              = 2'h1,
    DOUBLE_COORD_EIGHT_LANE_MODE = 2'h3,
    TWO_SAMPLE_VECTOR_MODE       = 2'h2
  } spw_mode_t;

  // Message kinds that change parameter type or writeback length
  typedef enum logic [1:0] {
    MT_SAMPLE      = 2'h0,
    MT_SAMPLE_KILL = 2'h1,
    MT_TEXEL_LOAD  = 2'h2,
    MT_SIZE_QUERY  = 2'h3
  } spw_msg_t;

  // Gray-coded message phase
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_REQ  = 2'b01,
    ST_WAIT = 2'b11,
    ST_RESP = 2'b10
  } spw_state_t;

  // Number of enabled channels (mask bit high means skipped)
  function automatic logic [2:0] spw_nch(input logic [3:0] chmask);
    logic [2:0] n;
    n = 3'h0;
    for (int c = 0; c < NCH; c++) begin
      if (!chmask[c]) begin
        n = n + 3'h1;
      end
    end
    return n;
  endfunction

  // Writeback register count for a request
  function automatic logic [3:0] spw_resp_len(input spw_mode_t mode, input logic fmt16,
                                              input logic [3:0] chmask, input logic null_en,
                                              input spw_msg_t mtype);
    logic [3:0] n;
    logic       extra;
    n = {1'b0, spw_nch(chmask)};
    if (mode == TWO_SAMPLE_VECTOR_MODE) begin
      n = 4'h1;
    end else if (mode == SIXTEEN_LANE_MODE && !fmt16) begin
      n = {n[2:0], 1'b0};
    end
    extra = null_en || (mode != SIXTEEN_LANE_MODE && mode != TWO_SAMPLE_VECTOR_MODE && !fmt16
                        && mtype == MT_SAMPLE_KILL);
    return n + {3'h0, extra};
  endfunction
endpackage
